// >>> design/sbr_defs.vh
// Constants for the serial buffer register block.
`ifndef SBR_DEFS_VH
`define SBR_DEFS_VH

// Register indices; the byte address is four times the index.
`define SBR_IDX_MODE          8'h01
`define SBR_IDX_CHAR_SIZE     8'h03
`define SBR_IDX_TX_DATA       8'h0a
`define SBR_IDX_TX_FILL       8'h0b
`define SBR_IDX_RX_PEEK       8'h0c
`define SBR_IDX_RX_POP        8'h0d
`define SBR_IDX_RX_FILL       8'h0e
`define SBR_IDX_RX_W16_LITTLE 8'h0f
`define SBR_IDX_RX_W16_BIG    8'h10
`define SBR_IDX_RX_W32_LITTLE 8'h11
`define SBR_IDX_RX_W32_BIG    8'h12
`define SBR_IDX_ERR_COUNT     8'h13
`define SBR_IDX_IRQ_STATUS    8'h20
`define SBR_IDX_IRQ_MASK      8'h21

// Buffer geometry.
`define SBR_DEPTH             16'h8000
`define SBR_PTR_W             15
`define SBR_CNT_W             16

// Mode values and reset values.
`define SBR_MODE_USER         8'h02
`define SBR_MODE_RESET        8'h03
`define SBR_SIZE_RESET        4'h8
`define SBR_SIZE_MIN          4'h5
`define SBR_SIZE_MAX          4'h8
`define SBR_ERR_MAX           31'h7fffffff

// Interrupt status bit positions.
`define SBR_IRQ_RX_AVAIL      0
`define SBR_IRQ_TX_EMPTY      1
`define SBR_IRQ_RX_OVERFLOW   2
`define SBR_IRQ_RX_ERROR      3
`define SBR_IRQ_W             4

`endif

// >>> design/sbr_serial_buffer.v
// Serial buffer register block with APB slave, character buffers and IRQ.
// Usage notes. The block answers every transfer with no wait state; read
// data and the number of characters a read will remove are fixed at the
// end of the setup cycle, so a character that arrives during the access
// phase is kept for the next read. Nothing is received or sent until the
// mode register holds the user value, and writing that value empties both
// buffers, losing whatever they held. Software polls the transmit level
// before each write, as a full buffer drops the character silently.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

`include "sbr_defs.vh"

module sbr_serial_buffer (
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [31:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        rx_valid_i,
    input  wire [7:0]  rx_data_i,
    input  wire        rx_error_i,
    output wire        tx_valid_o,
    output wire [7:0]  tx_data_o,
    input  wire        tx_ready_i,
    output wire        irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Mask a character to the configured number of data bits.
    // Sizes below five never reach here; the register refuses them.
    function [7:0] char_mask;
        input [7:0] ch;
        input [3:0] size;
        begin
            char_mask = ch & (8'hff >> (4'h8 - size));
        end
    endfunction

    // Advance a buffer pointer with wrap-around.
    function [`SBR_PTR_W-1:0] ptr_add;
        input [`SBR_PTR_W-1:0] ptr;
        input [2:0]            step;
        begin
            ptr_add = ptr + {{(`SBR_PTR_W-3){1'b0}}, step};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    // Both buffers are plain flip-flop arrays indexed by wrapping pointers.
    // The level counters are one bit wider than the pointers so that a full
    // buffer, with equal pointers, is told apart from an empty one.
    reg [7:0]            tx_mem [0:`SBR_DEPTH-1];
    reg [7:0]            rx_mem [0:`SBR_DEPTH-1];
    reg [`SBR_PTR_W-1:0] tx_wr;
    reg [`SBR_PTR_W-1:0] tx_rd;
    reg [`SBR_CNT_W-1:0] tx_count;
    reg [`SBR_PTR_W-1:0] rx_wr;
    reg [`SBR_PTR_W-1:0] rx_rd;
    reg [`SBR_CNT_W-1:0] rx_count;
    reg [7:0]            tx_last;
    reg [7:0]            mode;
    reg [3:0]            char_size;
    reg [30:0]           err_count;
    reg [`SBR_IRQ_W-1:0] irq_status;
    reg [`SBR_IRQ_W-1:0] irq_mask;
    reg [31:0]           rd_data;
    reg                  rd_err;
    reg [2:0]            rd_pop;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Only the low index bits select a register; any higher address bit or
    // a byte offset inside a word makes the transfer an error.
    wire [7:0] idx      = paddr_i[9:2];
    wire       addr_ok  = (paddr_i[31:10] == 22'h000000) &&
                          (paddr_i[1:0] == 2'h0);
    wire       setup    = psel_i && !penable_i;
    wire       access   = psel_i && penable_i;
    wire       wr_acc   = access && pwrite_i && !rd_err;
    wire       rd_acc   = access && !pwrite_i;
    wire       user     = (mode == `SBR_MODE_USER);

    // Zero wait state slave; errors were decided in the setup cycle.
    assign pready_o  = 1'b1;
    assign pslverr_o = access && rd_err;
    assign prdata_o  = rd_data;

    // Oldest four receive characters, in arrival order.
    wire [7:0] rx_c0 = rx_mem[rx_rd];
    wire [7:0] rx_c1 = rx_mem[ptr_add(rx_rd, 3'h1)];
    wire [7:0] rx_c2 = rx_mem[ptr_add(rx_rd, 3'h2)];
    wire [7:0] rx_c3 = rx_mem[ptr_add(rx_rd, 3'h3)];

    ////////////////////////////////////////////////////////////////////////
    // Read data selection, evaluated in the setup cycle.

    // Receive reads that find too few characters return zero and remove
    // nothing, so a polling loop can read blindly without losing data.
    reg [31:0] next_rd_data;
    reg [2:0]  next_rd_pop;
    reg        next_rd_err;
    always @* begin
        next_rd_data = 32'h00000000;
        next_rd_pop  = 3'h0;
        next_rd_err  = 1'b0;
        if (!addr_ok) begin
            next_rd_err = 1'b1;
        end else begin
            case (idx)
                `SBR_IDX_MODE: begin
                    next_rd_data = {24'h000000, mode};
                end
                `SBR_IDX_CHAR_SIZE: begin
                    next_rd_data = {28'h0000000, char_size};
                end
                `SBR_IDX_TX_DATA: begin
                    next_rd_data = {24'h000000, tx_last};
                end
                `SBR_IDX_TX_FILL: begin
                    next_rd_data = {16'h0000, tx_count};
                end
                `SBR_IDX_RX_PEEK: begin
                    if (rx_count > 16'h0000) begin
                        next_rd_data = {24'h000000, rx_c0};
                    end
                end
                `SBR_IDX_RX_POP: begin
                    if (rx_count > 16'h0000) begin
                        next_rd_data = {24'h000000, rx_c0};
                        next_rd_pop  = 3'h1;
                    end
                end
                `SBR_IDX_RX_FILL: begin
                    next_rd_data = {16'h0000, rx_count};
                end
                `SBR_IDX_RX_W16_LITTLE: begin
                    if (rx_count > 16'h0001) begin
                        next_rd_data = {16'h0000, rx_c1, rx_c0};
                        next_rd_pop  = 3'h2;
                    end
                end
                `SBR_IDX_RX_W16_BIG: begin
                    if (rx_count > 16'h0001) begin
                        next_rd_data = {16'h0000, rx_c0, rx_c1};
                        next_rd_pop  = 3'h2;
                    end
                end
                `SBR_IDX_RX_W32_LITTLE: begin
                    if (rx_count > 16'h0003) begin
                        next_rd_data = {rx_c3, rx_c2, rx_c1, rx_c0};
                        next_rd_pop  = 3'h4;
                    end
                end
                `SBR_IDX_RX_W32_BIG: begin
                    if (rx_count > 16'h0003) begin
                        next_rd_data = {rx_c0, rx_c1, rx_c2, rx_c3};
                        next_rd_pop  = 3'h4;
                    end
                end
                `SBR_IDX_ERR_COUNT: begin
                    next_rd_data = {1'b0, err_count};
                end
                `SBR_IDX_IRQ_STATUS: begin
                    next_rd_data = {28'h0000000, irq_status};
                end
                `SBR_IDX_IRQ_MASK: begin
                    next_rd_data = {28'h0000000, irq_mask};
                end
                default: begin
                    next_rd_err = 1'b1;
                end
            endcase
        end
    end

    // Latch read data and the pop decision at the end of setup. Between
    // setup and access only pushes can occur, so the decision stays valid.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rd_data <= 32'h00000000;
            rd_pop  <= 3'h0;
            rd_err  <= 1'b0;
        end else if (setup) begin
            rd_data <= next_rd_data;
            rd_pop  <= pwrite_i ? 3'h0 : next_rd_pop;
            rd_err  <= next_rd_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    // Writing the user mode value restarts both buffers from empty, even
    // when the mode already held that value.
    wire clear_bufs = wr_acc && (idx == `SBR_IDX_MODE) &&
                      (pwdata_i[7:0] == `SBR_MODE_USER);
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mode      <= `SBR_MODE_RESET;
            char_size <= `SBR_SIZE_RESET;
            irq_mask  <= {`SBR_IRQ_W{1'b0}};
        end else if (wr_acc) begin
            if (idx == `SBR_IDX_MODE) begin
                mode <= pwdata_i[7:0];
            end
            // Values outside five to eight are ignored.
            if (idx == `SBR_IDX_CHAR_SIZE &&
                pwdata_i[31:4] == 28'h0000000 &&
                pwdata_i[3:0] >= `SBR_SIZE_MIN &&
                pwdata_i[3:0] <= `SBR_SIZE_MAX) begin
                char_size <= pwdata_i[3:0];
            end
            if (idx == `SBR_IDX_IRQ_MASK) begin
                irq_mask <= pwdata_i[`SBR_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit buffer.

    // A full buffer drops the write; software checks the level first.
    wire tx_push = wr_acc && (idx == `SBR_IDX_TX_DATA) &&
                   (tx_count < `SBR_DEPTH);
    wire tx_pop  = tx_valid_o && tx_ready_i;

    assign tx_valid_o = user && (tx_count != 16'h0000);
    assign tx_data_o  = tx_mem[tx_rd];

    always @(posedge ref_clk_i) begin
        if (tx_push) begin
            tx_mem[tx_wr] <= char_mask(pwdata_i[7:0], char_size);
        end
    end

    // Pointers and level; configuration empties the buffer.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_wr    <= {`SBR_PTR_W{1'b0}};
            tx_rd    <= {`SBR_PTR_W{1'b0}};
            tx_count <= {`SBR_CNT_W{1'b0}};
            tx_last  <= 8'h00;
        end else if (clear_bufs) begin
            tx_wr    <= {`SBR_PTR_W{1'b0}};
            tx_rd    <= {`SBR_PTR_W{1'b0}};
            tx_count <= {`SBR_CNT_W{1'b0}};
        end else begin
            if (tx_push) begin
                tx_wr   <= ptr_add(tx_wr, 3'h1);
                tx_last <= char_mask(pwdata_i[7:0], char_size);
            end
            if (tx_pop) begin
                tx_rd <= ptr_add(tx_rd, 3'h1);
            end
            tx_count <= tx_count + {15'h0000, tx_push}
                                 - {15'h0000, tx_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer.

    // A character arriving at a full buffer is lost; it is counted as an
    // error and flagged as an overflow so that software can notice.
    wire rx_full  = (rx_count == `SBR_DEPTH);
    wire rx_push  = user && rx_valid_i && !rx_full;
    wire rx_drop  = user && rx_valid_i && rx_full;
    wire [2:0] rx_take = rd_acc ? rd_pop : 3'h0;

    always @(posedge ref_clk_i) begin
        if (rx_push) begin
            rx_mem[rx_wr] <= char_mask(rx_data_i, char_size);
        end
    end

    // Pointers and level; a pop removes one, two or four characters.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rx_wr    <= {`SBR_PTR_W{1'b0}};
            rx_rd    <= {`SBR_PTR_W{1'b0}};
            rx_count <= {`SBR_CNT_W{1'b0}};
        end else if (clear_bufs) begin
            rx_wr    <= {`SBR_PTR_W{1'b0}};
            rx_rd    <= {`SBR_PTR_W{1'b0}};
            rx_count <= {`SBR_CNT_W{1'b0}};
        end else begin
            if (rx_push) begin
                rx_wr <= ptr_add(rx_wr, 3'h1);
            end
            rx_rd    <= ptr_add(rx_rd, rx_take);
            rx_count <= rx_count + {15'h0000, rx_push}
                                 - {13'h0000, rx_take};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error counter: saturating; an error in the clearing cycle counts.

    // The counter stops at its ceiling instead of wrapping, so a large
    // value always means many errors and never a small count after a wrap.
    wire err_clr = wr_acc && (idx == `SBR_IDX_ERR_COUNT);
    wire err_inc = rx_error_i || rx_drop;
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            err_count <= 31'h00000000;
        end else if (err_clr) begin
            err_count <= err_inc ? 31'h00000001 : 31'h00000000;
        end else if (err_inc && err_count != `SBR_ERR_MAX) begin
            err_count <= err_count + 31'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, write one to clear, set wins over clear.

    reg [`SBR_IRQ_W-1:0] irq_set;
    always @* begin
        irq_set = {`SBR_IRQ_W{1'b0}};
        irq_set[`SBR_IRQ_RX_AVAIL]    = rx_push;
        // A push in the same cycle keeps the buffer from going empty.
        irq_set[`SBR_IRQ_TX_EMPTY]    = tx_pop && !tx_push &&
                                        (tx_count == 16'h0001);
        irq_set[`SBR_IRQ_RX_OVERFLOW] = rx_drop;
        irq_set[`SBR_IRQ_RX_ERROR]    = rx_error_i;
    end

    wire [`SBR_IRQ_W-1:0] irq_clr =
        (wr_acc && idx == `SBR_IDX_IRQ_STATUS) ?
        pwdata_i[`SBR_IRQ_W-1:0] : {`SBR_IRQ_W{1'b0}};

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_status <= {`SBR_IRQ_W{1'b0}};
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    // Level interrupt while any unmasked status bit is set.
    assign irq_o = |(irq_status & irq_mask);

endmodule

`default_nettype wire

// >>> testbench/sbr_remote.sv
// Remote serial device model on the line side of the block.
`timescale 1ns/1ps
`default_nettype none
module sbr_remote (
    input  wire logic       ref_clk_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       hold_i,
    input  wire logic       slow_i,
    output var  logic       tx_ready_o,
    output var  logic       rx_valid_o,
    output var  logic [7:0] rx_data_o,
    output var  logic       rx_error_o
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'h0;
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h5a;
        rx_error_o = 1'b0;
    end
    // Takes characters promptly, one edge in four when slow, none on hold.
    always @(posedge ref_clk_i) begin
        ph <= ph + 2'h1;
        if (tx_valid_i && tx_ready_o)
            got.push_back(tx_data_i);
        tx_ready_o <= !hold_i && (!slow_i || ph == 2'h3);
    end
    // One received character; the data line is inverted once released.
    task send(input logic [7:0] c);
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= c;
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~c;
    endtask
    task flag_error();
        @(posedge ref_clk_i);
        rx_error_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_error_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/sbr_serial_buffer_props.sv
// Port-level assertions for the serial buffer register block.
`timescale 1ns/1ps
`default_nettype none
module sbr_props (
    input wire logic        ref_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        rx_valid_i,
    input wire logic [7:0]  rx_data_i,
    input wire logic        rx_error_i,
    input wire logic        tx_valid_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_ready_i,
    input wire logic        irq_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Setup of a read, and a complete write of user mode.
    sequence s_rd(a);
        psel_i && !penable_i && !pwrite_i && paddr_i == a;
    endsequence
    sequence s_mode2;
        psel_i && !penable_i && pwrite_i && paddr_i == 32'h4
            && pwdata_i == 32'h2 ##1 psel_i && penable_i;
    endsequence
    property p_rd_hold;
        !(psel_i && !penable_i) |=> $stable(prdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved outside a setup cycle");
    property p_char_w;
        s_rd(32'h30) or s_rd(32'h34) |=> prdata_o[31:8] == 24'h0;
    endproperty
    a_char_w: assert property (p_char_w)
        else $error("single character read wider than a byte");
    property p_w16;
        s_rd(32'h3c) or s_rd(32'h40) |=> prdata_o[31:16] == 16'h0;
    endproperty
    a_w16: assert property (p_w16)
        else $error("two character word wider than 16 bits");
    property p_fill;
        s_rd(32'h2c) or s_rd(32'h38) |=> prdata_o <= 32'h8000;
    endproperty
    a_fill: assert property (p_fill)
        else $error("fill level above capacity");
    property p_err;
        s_rd(32'h4c) |=> !prdata_o[31];
    endproperty
    a_err: assert property (p_err)
        else $error("error count above its range");
    property p_clear;
        s_mode2 |=> !tx_valid_o;
    endproperty
    a_clear: assert property (p_clear)
        else $error("transmit buffer not emptied by user mode");
    property p_tx_hold;
        tx_valid_o && !tx_ready_i && !pwrite_i
            |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit head changed while stalled");
    property p_slverr;
        pslverr_o |-> psel_i && penable_i;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error response outside access phase");
    property p_irq_fall;
        $fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
endmodule
bind sbr_serial_buffer sbr_props sbr_props_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_error_i(rx_error_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .irq_o(irq_o)
);
`default_nettype wire

// >>> testbench/serial_buffer_register_access_tb.sv
// Self-checking bench for the serial buffer register block.
`timescale 1ns/1ps
`default_nettype none
module serial_buffer_register_access_tb;
    logic        clk, rst, psel, pen, pwr, prdy, perr, rxv, rxe, txv, txr;
    logic        irq, hold, slow, e;
    logic [31:0] paddr, pwd, prd, d;
    logic [31:0] lf = 32'hbeee;
    logic [7:0]  rxd, txd, msk;
    logic [7:0]  rxq[$], txq[$];
    int          errors = 0, num_checks = 0, cyc = 0;
    sbr_serial_buffer sbr_serial_buffer_inst (
        .ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .rx_valid_i(rxv),
        .rx_data_i(rxd), .rx_error_i(rxe), .tx_valid_o(txv),
        .tx_data_o(txd), .tx_ready_i(txr), .irq_o(irq));
    sbr_remote sbr_remote_inst (
        .ref_clk_i(clk), .tx_valid_i(txv), .tx_data_i(txd), .hold_i(hold),
        .slow_i(slow), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd),
        .rx_error_o(rxe));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    // Packs n modelled characters, oldest low or oldest high.
    function automatic logic [31:0] wrd(input int n, input bit big);
        logic [31:0] r = 32'h0;
        for (int k = 0; k < n; k++)
            r[8*(big ? n-1-k : k) +: 8] = rxq.pop_front();
        return r;
    endfunction
    task apb(input logic w, input logic [7:0] i, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= {22'h0, i, 2'b00};
        pwd <= v;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        d = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rdc(input logic [7:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0);
        chk(d, exp);
    endtask
    task sendr();
        logic [7:0] c;
        c = rnd();
        rxq.push_back(c & msk);
        sbr_remote_inst.send(c);
    endtask
    // Main sequence.
    initial begin
        int k;
        logic [7:0] c;
        {psel, pen, pwr, hold, slow} = 5'h0;
        paddr = 32'h0;
        pwd = 32'h0;
        msk = 8'hff;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h03, 32'h8);
        rdc(8'h0b, 32'h0);
        for (k = 0; k < 6; k++)
            rdc((k < 2) ? 8'(8'h0c + k) : 8'(8'h0d + k), 32'h0);
        rdc(8'h0e, 32'h0);
        apb(1'b1, 8'h01, 32'h2);
        rdc(8'h01, 32'h2);
        for (k = 0; k < 13; k++) sendr();
        rdc(8'h0e, 32'd13);
        rdc(8'h0c, rxq[0]);
        rdc(8'h0e, 32'd13);
        rdc(8'h0d, rxq.pop_front());
        rdc(8'h0d, rxq.pop_front());
        rdc(8'h0e, 32'd11);
        rdc(8'h0f, wrd(2, 0));
        rdc(8'h10, wrd(2, 1));
        rdc(8'h11, wrd(4, 0));
        rdc(8'h12, 32'h0);
        rdc(8'h0e, 32'd3);
        sendr();
        rdc(8'h12, wrd(4, 1));
        sendr();
        rdc(8'h0f, 32'h0);
        rdc(8'h0d, rxq.pop_front());
        for (k = 5; k < 10; k++) begin
            apb(1'b1, 8'h03, k);
            msk = (k < 9) ? 8'((1 << k) - 1) : msk;
            sendr();
            rdc(8'h0d, rxq.pop_front());
        end
        rdc(8'h03, 32'h8);
        hold <= 1'b1;
        for (k = 0; k < 3; k++) begin
            apb(1'b0, 8'h0b, 32'h0);
            if (d < 32'h8000) begin
                c = rnd();
                apb(1'b1, 8'h0a, {24'h0, c});
                txq.push_back(c);
            end
        end
        rdc(8'h0b, 32'd3);
        rdc(8'h0a, {24'h0, txq[2]});
        hold <= 1'b0;
        slow <= 1'b1;
        while (sbr_remote_inst.got.size() < txq.size()) @(posedge clk);
        for (k = 0; k < txq.size(); k++)
            chk(sbr_remote_inst.got[k], txq[k]);
        rdc(8'h0b, 32'h0);
        repeat (3) sbr_remote_inst.flag_error();
        rdc(8'h13, 32'd3);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, 8'h21, (k == 1) ? 0 : 8);
            @(negedge clk);
            chk({31'h0, irq}, (k == 1) ? 0 : 1);
        end
        rdc(8'h21, 32'h8);
        apb(1'b1, 8'h20, 32'h8);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(8'h20, 32'h3);
        apb(1'b1, 8'h13, 32'h0);
        rdc(8'h13, 32'h0);
        hold <= 1'b1;
        sendr();
        apb(1'b1, 8'h0a, 32'h41);
        apb(1'b1, 8'h01, 32'h2);
        rxq.delete();
        rdc(8'h0e, 32'h0);
        rdc(8'h0b, 32'h0);
        apb(1'b0, 8'h3f, 32'h0);
        chk({e, d[30:0]}, 32'h80000000);
        report_and_stop();
    end
endmodule
`default_nettype wire
